// *** rtl/cgc_pkg.sv ***
// Package for the clock generation control block: register map, field
// layouts, reset values, encodings and the packed carriers of the ports.
// Assumes a 32-bit APB slave port and oscillator levels synchronous to pclk.
package cgc_pkg;

    // ==========================================================
    // Register indices (printed offsets) and byte addresses
    localparam logic [11:0] CTRL0_IDX = 12'h006;
    localparam logic [11:0] PROT_IDX = 12'h007;
    localparam logic [11:0] AUX_IDX = 12'h008;
    localparam logic [11:0] STAT_IDX = 12'h009;
    localparam logic [11:0] CTRL0_ADDR = {CTRL0_IDX[9:0], 2'b00};
    localparam logic [11:0] PROT_ADDR = {PROT_IDX[9:0], 2'b00};
    localparam logic [11:0] AUX_ADDR = {AUX_IDX[9:0], 2'b00};
    localparam logic [11:0] STAT_ADDR = {STAT_IDX[9:0], 2'b00};

    // ==========================================================
    // Field layouts
    typedef struct packed {
        logic cpu_clk_sub_sel;
        logic wdog_action_sel;
        logic main_osc_stop;
        logic sub_osc_enable;
        logic sub_osc_drive;
        logic wait_periph_gate;
        logic clk_out_sel_hi;
        logic clk_out_sel_lo;
    } cgc_ctrl0_s;

    typedef struct packed {
        logic synth_sel;
        logic synth_run;
        logic osc_stop_detect_en;
        logic internal_osc_sel;
        logic clock_change_lock;
        logic [4:0] cpu_clk_divider;
    } cgc_aux_s;

    typedef struct packed {
        logic osc_lost_flag;
        logic main_osc_running;
        logic sub_osc_running;
        logic int_osc_running;
        logic cpu_on_sub;
    } cgc_stat_s;

    localparam logic [7:0] CTRL0_RESET = 8'h08;
    localparam logic [9:0] AUX_RESET = 10'h008;
    localparam logic [4:0] DIV_BY_8 = 5'h08;
    localparam logic [4:0] DIV_NONE_CODE = 5'h12;
    localparam logic [4:0] DIV_ZERO_CODE = 5'h00;
    localparam logic [4:0] DIV_BY_1 = 5'h01;
    localparam logic [4:0] DIV_BY_16 = 5'h10;
    localparam int unsigned F8_BIT = 2;
    localparam int unsigned F32_BIT = 4;

    // ==========================================================
    // Encodings
    typedef enum logic [1:0] {
        CLKO_GPIO = 2'h0,
        CLKO_SUB = 2'h1,
        CLKO_DIV8 = 2'h2,
        CLKO_DIV32 = 2'h3
    } cgc_clko_e;

    typedef enum logic [1:0] {
        XPIN_BUS_CLK = 2'h0,
        XPIN_ALE = 2'h1,
        XPIN_LOW = 2'h2
    } cgc_xpin_e;

    // Base source mux inputs
    localparam logic [1:0] BASE_MAIN = 2'h0;
    localparam logic [1:0] BASE_INT = 2'h1;
    localparam logic [1:0] BASE_SYNTH = 2'h2;

    // ==========================================================
    // Port carriers
    typedef struct packed {
        logic main_lvl;
        logic sub_lvl;
        logic int_lvl;
        logic synth_lvl;
        logic main_lost;
    } cgc_osc_in_s;

    typedef struct packed {
        logic wait_mode;
        logic stop_mode;
        logic low_power;
        logic ext_bus_mode;
        cgc_xpin_e ext_pin_sel;
        logic bus_clk_lvl;
        logic ale_lvl;
        logic gpio_lvl;
    } cgc_mode_s;

    typedef struct packed {
        logic main_run;
        logic main_out_high;
        logic main_fb_on;
        logic sub_run;
        logic sub_fb_on;
        logic sub_drive_hi;
        logic int_run;
        logic synth_run;
    } cgc_osc_ctl_s;

    typedef struct packed {
        logic cpu_clk;
        logic periph_clk;
        logic periph_div8_clock;
        logic periph_div32_clock;
        logic sub_div32_clock;
        logic sub_rate_clock;
        logic clock_output_pin;
        logic clock_output_is_gpio;
        logic wdog_reset_sel;
    } cgc_clk_out_s;

endpackage

// *** rtl/cgc_clk_switch.sv ***
// Glitch-free selector for clock levels sampled in the pclk domain.
// Assumes every source level is synchronous to pclk.
`timescale 1ns/10ps
module cgc_clk_switch #(
    parameter int unsigned N = 2,
    parameter int unsigned W = 1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Sources and selection
    input wire logic [N-1:0] src,
    input wire logic [W-1:0] sel,
    // Selected level
    output logic clk_out
);

    typedef struct packed {
        logic [W-1:0] cur;
        logic lvl;
    } cgc_sw_state_s;

    cgc_sw_state_s st;
    cgc_sw_state_s next_st;

    // ==========================================================
    // Switch only while both the old and new level are low, so
    // neither phase is ever cut short
    always_comb begin
        next_st = st;
        if (sel != st.cur && !st.lvl && !src[sel]) begin
            next_st.cur = sel;
        end
        next_st.lvl = src[next_st.cur];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign clk_out = st.lvl;

endmodule

// *** rtl/cgc_clock_ctrl.sv ***
// Clock generation control: control register 0, protect and auxiliary
// registers on APB, source selection, dividers and the clock output pin.
// Assumes oscillator levels and mode inputs are synchronous to pclk.
`timescale 1ns/10ps

// Overview of operation
// - Reset: main oscillator runs, CPU gets main/8
// - Reset: sub oscillator stopped, feedback resistor off
// - Output select: port, sub, f8, f32
// - Expansion modes: pin gives bus clock, strobe, low
// - Gating bit stops peripheral clocks in wait
// - Sub divided-by-32 clock never gated by wait
// - Drive bit low/high; stop mode forces high
// - Main stop halts oscillator, output high
// - Main stop forces divider eight unless internal
// - Stop bit is not the oscillator status
// - Watchdog action bit, once set, stays set
// - CPU select: sub at one, else divided
// - Lock bit blocks gating, stop, CPU select
// - Stop mode halts all clocks, resistors off
// - Main loss with detection switches to internal
module cgc_clock_ctrl (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Oscillators and operating modes
    input wire cgc_pkg::cgc_osc_in_s osc_in,
    input wire cgc_pkg::cgc_mode_s mode,
    // Oscillator controls
    output cgc_pkg::cgc_osc_ctl_s osc_ctl,
    // Clock outputs
    output cgc_pkg::cgc_clk_out_s clk_out,
    output logic [4:0] cpu_clk_divider
);
    import cgc_pkg::*;

    typedef struct packed {
        cgc_ctrl0_s ctrl0;
        cgc_aux_s aux;
        logic prot_en;
        logic lost_flag;
        logic [31:0] rdata;
        logic err;
        logic base_q;
        logic [4:0] div_cnt;
        logic cpu_div_lvl;
        logic pfc_q;
        logic [4:0] pfc_cnt;
        logic sub_q;
        logic [4:0] sub_cnt;
        cgc_osc_ctl_s osc;
        cgc_clk_out_s clk;
    } cgc_state_s;

    cgc_state_s st;
    cgc_state_s next_st;

    logic base_lvl;
    logic cpu_lvl;
    logic [1:0] base_sel;
    logic setup;
    logic access;
    logic wr_ctrl0;
    logic wr_prot;
    logic wr_aux;
    logic mapped;
    logic [4:0] div_n;
    logic stop_q;
    logic pfc_gate;
    logic pfc_lvl;
    cgc_stat_s stat;
    cgc_ctrl0_s wctrl0;
    cgc_aux_s waux;

    // ==========================================================
    // Source selection
    always_comb begin
        if (st.aux.internal_osc_sel) begin
            base_sel = BASE_INT;
        end else if (st.aux.synth_sel) begin
            base_sel = BASE_SYNTH;
        end else begin
            base_sel = BASE_MAIN;
        end
    end

    cgc_clk_switch #(.N(3), .W(2)) u_base_sw (
        .pclk(pclk),
        .presetn(presetn),
        .src({osc_in.synth_lvl & st.osc.synth_run,
              osc_in.int_lvl & st.osc.int_run,
              osc_in.main_lvl & st.osc.main_run}),
        .sel(base_sel),
        .clk_out(base_lvl)
    );

    cgc_clk_switch #(.N(2), .W(1)) u_cpu_sw (
        .pclk(pclk),
        .presetn(presetn),
        .src({osc_in.sub_lvl & st.osc.sub_run, st.cpu_div_lvl}),
        .sel(st.ctrl0.cpu_clk_sub_sel),
        .clk_out(cpu_lvl)
    );

    // ==========================================================
    // APB decode
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign pready = access;
    assign prdata = st.rdata;
    assign pslverr = access && st.err;
    assign mapped = paddr == CTRL0_ADDR || paddr == PROT_ADDR ||
                    paddr == AUX_ADDR || paddr == STAT_ADDR;
    // Protect bit gates control register 0; the rest are always open
    assign wr_ctrl0 = access && pwrite && paddr == CTRL0_ADDR && st.prot_en;
    assign wr_prot = access && pwrite && paddr == PROT_ADDR;
    assign wr_aux = access && pwrite && paddr == AUX_ADDR;
    assign stop_q = mode.stop_mode;

    always_comb begin
        stat.osc_lost_flag = st.lost_flag;
        stat.main_osc_running = st.osc.main_run;
        stat.sub_osc_running = st.osc.sub_run;
        stat.int_osc_running = st.osc.int_run;
        stat.cpu_on_sub = st.ctrl0.cpu_clk_sub_sel;
    end

    // Divider code: no-division code and zero are the two special cases
    always_comb begin
        if (st.aux.cpu_clk_divider == DIV_NONE_CODE) begin
            div_n = DIV_BY_1;
        end else if (st.aux.cpu_clk_divider == DIV_ZERO_CODE) begin
            div_n = DIV_BY_16;
        end else begin
            div_n = st.aux.cpu_clk_divider;
        end
    end

    // Synth also derives from main, so only the internal source survives
    assign pfc_gate = stop_q || (mode.wait_mode && st.ctrl0.wait_periph_gate) ||
                      (st.ctrl0.main_osc_stop && base_sel != BASE_INT);
    assign pfc_lvl = base_lvl && !pfc_gate;

    // ==========================================================
    // Next state
    always_comb begin
        next_st = st;
        wctrl0 = cgc_ctrl0_s'(pwdata[7:0]);
        waux = cgc_aux_s'(pwdata[9:0]);

        // Register read data is captured in the setup phase
        if (setup) begin
            next_st.err = !mapped;
            case (paddr)
                CTRL0_ADDR: next_st.rdata = {24'h00_0000, st.ctrl0};
                PROT_ADDR: next_st.rdata = {31'h0000_0000, st.prot_en};
                AUX_ADDR: next_st.rdata = {22'h00_0000, st.aux};
                STAT_ADDR: next_st.rdata = {27'h000_0000, stat};
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end

        if (wr_prot) begin
            next_st.prot_en = pwdata[0];
        end
        if (wr_aux) begin
            next_st.aux = waux;
            // Writing zero clears the loss flag; a new loss still wins
            if (!pwdata[31]) begin
                next_st.lost_flag = 1'b0;
            end
        end

        if (wr_ctrl0) begin
            next_st.ctrl0.clk_out_sel_lo = wctrl0.clk_out_sel_lo;
            next_st.ctrl0.clk_out_sel_hi = wctrl0.clk_out_sel_hi;
            next_st.ctrl0.sub_osc_drive = wctrl0.sub_osc_drive;
            next_st.ctrl0.sub_osc_enable = wctrl0.sub_osc_enable;
            next_st.ctrl0.wdog_action_sel = st.ctrl0.wdog_action_sel |
                                            wctrl0.wdog_action_sel;
            if (!st.aux.clock_change_lock) begin
                next_st.ctrl0.wait_periph_gate = wctrl0.wait_periph_gate;
                next_st.ctrl0.main_osc_stop = wctrl0.main_osc_stop;
                next_st.ctrl0.cpu_clk_sub_sel = wctrl0.cpu_clk_sub_sel;
                if (wctrl0.main_osc_stop && !st.ctrl0.main_osc_stop &&
                    !st.aux.internal_osc_sel) begin
                    next_st.aux.cpu_clk_divider = DIV_BY_8;
                end
            end
        end

        if (stop_q) begin
            next_st.ctrl0.sub_osc_drive = 1'b1;
            next_st.aux.cpu_clk_divider = DIV_BY_8;
        end

        // Main clock loss moves CPU and peripherals to the internal source
        if (st.aux.osc_stop_detect_en && osc_in.main_lost) begin
            next_st.aux.internal_osc_sel = 1'b1;
            next_st.lost_flag = 1'b1;
        end

        // Oscillator controls
        next_st.osc.main_run = !stop_q && !mode.low_power &&
                               !next_st.ctrl0.main_osc_stop;
        next_st.osc.main_out_high = next_st.ctrl0.main_osc_stop;
        next_st.osc.main_fb_on = !stop_q;
        next_st.osc.sub_run = next_st.ctrl0.sub_osc_enable && !stop_q;
        next_st.osc.sub_fb_on = next_st.ctrl0.sub_osc_enable && !stop_q;
        next_st.osc.sub_drive_hi = next_st.ctrl0.sub_osc_drive;
        next_st.osc.int_run = next_st.aux.internal_osc_sel && !stop_q;
        next_st.osc.synth_run = next_st.aux.synth_run && !stop_q;

        // CPU divider on rising edges of the base source
        next_st.base_q = base_lvl;
        if (base_lvl && !st.base_q) begin
            if (st.div_cnt >= div_n - DIV_BY_1) begin
                next_st.div_cnt = '0;
            end else begin
                next_st.div_cnt = st.div_cnt + DIV_BY_1;
            end
        end
        if (div_n == DIV_BY_1) begin
            next_st.cpu_div_lvl = base_lvl;
        end else begin
            next_st.cpu_div_lvl = next_st.div_cnt < (div_n >> 1);
        end

        // Peripheral f8 and f32
        next_st.pfc_q = pfc_lvl;
        if (pfc_lvl && !st.pfc_q) begin
            next_st.pfc_cnt = st.pfc_cnt + DIV_BY_1;
        end

        // Sub divided by 32 ignores wait gating; stops only with the sub clock
        next_st.sub_q = osc_in.sub_lvl && st.osc.sub_run;
        if (next_st.sub_q && !st.sub_q) begin
            next_st.sub_cnt = st.sub_cnt + DIV_BY_1;
        end

        // Clock outputs
        next_st.clk.cpu_clk = cpu_lvl && !stop_q;
        next_st.clk.periph_clk = pfc_lvl;
        next_st.clk.periph_div8_clock = st.pfc_cnt[F8_BIT];
        next_st.clk.periph_div32_clock = st.pfc_cnt[F32_BIT];
        next_st.clk.sub_div32_clock = st.sub_cnt[F32_BIT];
        next_st.clk.sub_rate_clock = st.sub_q;
        next_st.clk.wdog_reset_sel = st.ctrl0.wdog_action_sel;
        next_st.clk.clock_output_is_gpio = !mode.ext_bus_mode &&
            {st.ctrl0.clk_out_sel_hi, st.ctrl0.clk_out_sel_lo} == CLKO_GPIO;
        if (mode.ext_bus_mode) begin
            case (mode.ext_pin_sel)
                XPIN_BUS_CLK: next_st.clk.clock_output_pin = mode.bus_clk_lvl;
                XPIN_ALE: next_st.clk.clock_output_pin = mode.ale_lvl;
                default: next_st.clk.clock_output_pin = 1'b0;
            endcase
        end else begin
            case ({st.ctrl0.clk_out_sel_hi, st.ctrl0.clk_out_sel_lo})
                CLKO_GPIO: next_st.clk.clock_output_pin = mode.gpio_lvl;
                CLKO_SUB: next_st.clk.clock_output_pin = st.sub_q;
                CLKO_DIV8: next_st.clk.clock_output_pin = st.pfc_cnt[F8_BIT];
                default: next_st.clk.clock_output_pin = st.pfc_cnt[F32_BIT];
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.ctrl0 <= cgc_ctrl0_s'(CTRL0_RESET);
            st.aux <= cgc_aux_s'(AUX_RESET);
            st.osc.main_run <= 1'b1;
            st.osc.main_fb_on <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign osc_ctl = st.osc;
    assign clk_out = st.clk;
    assign cpu_clk_divider = st.aux.cpu_clk_divider;

endmodule

// *** tb/cgc_osc_model.sv ***
// Behavioural oscillators on the far side of the clock control block.
// Assumes levels sampled by pclk; oscillator rates are scaled-down stand-ins.
`timescale 1ns/10ps
module cgc_osc_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Controls from the block and the bench
    input wire cgc_pkg::cgc_osc_ctl_s osc_ctl,
    input wire logic lose_main,
    // Levels to the block
    output cgc_pkg::cgc_osc_in_s osc_in
);
    import cgc_pkg::*;
    logic [3:0] phase;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 4'h0;
        end else begin
            phase <= phase + 4'h1;
        end
    end
    // Stopped crystal: driven-high output pulls the input up
    assign osc_in.main_lvl = osc_ctl.main_out_high |
                             (osc_ctl.main_run & ~lose_main & phase[1]);
    // Sub pins are plain inputs without pull-up, so they only swing when run
    assign osc_in.sub_lvl = osc_ctl.sub_run & phase[2];
    assign osc_in.int_lvl = osc_ctl.int_run & phase[2];
    assign osc_in.synth_lvl = osc_ctl.synth_run & phase[0];
    assign osc_in.main_lost = lose_main;
endmodule

// *** tb/cgc_clock_ctrl_properties.sv ***
// Concurrent checks on the clock control block ports.
// Assumes one clock, pclk, with presetn as its reset.
`timescale 1ns/10ps
module cgc_clock_ctrl_properties (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Watched ports
    input wire cgc_pkg::cgc_mode_s mode,
    input wire cgc_pkg::cgc_osc_ctl_s osc_ctl,
    input wire cgc_pkg::cgc_clk_out_s clk_out,
    input wire logic [4:0] cpu_clk_divider
);
    import cgc_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_stop3;
        mode.stop_mode [*3];
    endsequence
    sequence s_ext3;
        mode.ext_bus_mode [*3];
    endsequence
    a_reset_main: assert property (
        !$past(presetn) |-> osc_ctl.main_run && cpu_clk_divider == DIV_BY_8)
        else $error("Main clock or divider wrong after reset");
    a_reset_sub: assert property (
        !$past(presetn) |-> !osc_ctl.sub_run && !osc_ctl.sub_fb_on)
        else $error("Sub oscillator active after reset");
    a_stop_drive: assert property (
        mode.stop_mode |-> ##[1:3] osc_ctl.sub_drive_hi)
        else $error("Sub drive not forced high in stop mode");
    a_stop_halt: assert property (
        s_stop3 |-> !(osc_ctl.main_run || osc_ctl.sub_run || osc_ctl.main_fb_on
        || osc_ctl.sub_fb_on))
        else $error("Oscillator or resistor still on in stop mode");
    a_stop_frozen: assert property (
        s_stop3 ##1 s_stop3 |-> $stable(clk_out.cpu_clk) && $stable(clk_out.periph_clk))
        else $error("Clock moving in stop mode");
    a_main_halt: assert property (
        osc_ctl.main_out_high && !$past(mode.stop_mode) |->
        !osc_ctl.main_run && osc_ctl.main_fb_on)
        else $error("Main not halted with its resistor kept on");
    a_wdog_sticky: assert property (
        clk_out.wdog_reset_sel |=> clk_out.wdog_reset_sel)
        else $error("Watchdog reset select cleared");
    a_ext_no_gpio: assert property (
        s_ext3 |-> !clk_out.clock_output_is_gpio)
        else $error("Clock pin is a port in expansion mode");
    a_ext_low: assert property (
        (mode.ext_bus_mode && mode.ext_pin_sel[1]) [*3] |-> !clk_out.clock_output_pin)
        else $error("Clock pin not low when low level chosen");
endmodule
bind cgc_clock_ctrl cgc_clock_ctrl_properties i_cgc_clock_ctrl_properties (.pclk, .presetn,
    .mode, .osc_ctl, .clk_out, .cpu_clk_divider);

// *** tb/clock_generation_control_test.sv ***
// Self-checking bench for the clock generation control block.
// Assumes the oscillator model beside the design and the bound checker.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module clock_generation_control_test;
    import cgc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, lose, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv, d;
    logic [4:0] cpu_clk_divider;
    cgc_osc_in_s osc_in;
    cgc_mode_s mode;
    cgc_osc_ctl_s osc_ctl;
    cgc_clk_out_s clk_out;
    int n_fail, total_checks, ec[9];
    cgc_clock_ctrl i_cgc_clock_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .osc_in(osc_in), .mode(mode), .osc_ctl(osc_ctl),
        .clk_out(clk_out), .cpu_clk_divider(cpu_clk_divider));
    cgc_osc_model i_cgc_osc_model (.pclk(pclk), .presetn(presetn), .osc_ctl(osc_ctl),
        .lose_main(lose), .osc_in(osc_in));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // ==========================================================
    // Bus and measurement helpers
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic edges(input int n);
        cgc_clk_out_s p;
        foreach (ec[i]) ec[i] = 0;
        p = clk_out;
        repeat (n) begin
            @(posedge pclk);
            for (int i = 0; i < 9; i++) if (clk_out[i] && !p[i]) ec[i]++;
            p = clk_out;
        end
    endtask
    function automatic bit near(int a, int b);
        return a > 0 && a - b <= 1 && b - a <= 1;
    endfunction
    function automatic logic exp_gpio(logic ext, logic [1:0] sel);
        return !ext && sel == CLKO_GPIO;
    endfunction
    // Pin level for port or expansion use, from the random word's mode bits
    function automatic logic exp_pin(logic [31:0] r);
        if (!r[8]) return r[11];
        if (r[10]) return 1'b0;
        return r[9] ? r[12] : r[13];
    endfunction
    task automatic give_verdict();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #400000;
        n_fail++;
        give_verdict();
    end
    // ==========================================================
    // Tests
    initial begin
        void'($urandom(32'h30bc));
        {presetn, psel, penable, pwrite, lose, paddr, pwdata} = '0;
        mode = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK("div", DIV_BY_8, cpu_clk_divider)
        `CHK("sub", 2'b00, {osc_ctl.sub_run, osc_ctl.sub_fb_on})
        apb(0, CTRL0_ADDR, 0);
        `CHK("ctrl0", CTRL0_RESET, rv[7:0])
        apb(1, CTRL0_ADDR, 32'h0000_0001);
        apb(0, CTRL0_ADDR, 0);
        `CHK("locked", CTRL0_RESET, rv[7:0])
        apb(1, PROT_ADDR, 32'h0000_0001);
        apb(1, CTRL0_ADDR, 32'h0000_0018);
        `CHK("drive", 1'b1, osc_ctl.sub_drive_hi)
        $display("reset and protect done");
        for (int k = 0; k < 4; k++) begin
            apb(1, CTRL0_ADDR, 32'h18 | k);
            edges(600);
            `CHK("gpio", k == 0, clk_out.clock_output_is_gpio)
            if (k > 0) `CHK("pin", 1'b1, near(ec[2], ec[k == 1 ? 3 : k == 2 ? 6 : 5]))
            `CHK("cpu", 1'b1, near(ec[8], ec[6]))
        end
        $display("output select done");
        mode.wait_mode <= 1'b1;
        apb(1, CTRL0_ADDR, 32'h0000_001c);
        edges(600);
        `CHK("gated", 0, ec[7])
        `CHK("sub32", 1'b1, ec[4] > 0)
        apb(1, CTRL0_ADDR, 32'h0000_0018);
        edges(600);
        `CHK("ungated", 1'b1, ec[7] > 0)
        mode.wait_mode <= 1'b0;
        apb(1, CTRL0_ADDR, 32'h0000_0058);
        apb(1, CTRL0_ADDR, 32'h0000_0018);
        apb(0, CTRL0_ADDR, 0);
        `CHK("wdog", 8'h58, rv[7:0])
        `CHK("wdogout", 1'b1, clk_out.wdog_reset_sel)
        apb(1, AUX_ADDR, 32'h0000_0028);
        apb(1, CTRL0_ADDR, 32'h0000_00d4);
        apb(0, CTRL0_ADDR, 0);
        `CHK("lock", 8'h50, rv[7:0])
        apb(1, AUX_ADDR, 32'h0000_0008);
        apb(1, CTRL0_ADDR, 32'h0000_0058);
        $display("wait, watchdog, lock done");
        apb(1, AUX_ADDR, 32'h0000_0004);
        apb(1, CTRL0_ADDR, 32'h0000_00d8);
        edges(600);
        `CHK("cpusub", 1'b1, near(ec[8], ec[3]))
        apb(1, CTRL0_ADDR, 32'h0000_00f8);
        apb(0, AUX_ADDR, 0);
        `CHK("div8", DIV_BY_8, rv[4:0])
        `CHK("mstop", 3'b011, osc_ctl[7:5])
        apb(0, STAT_ADDR, 0);
        `CHK("mrun", 1'b0, rv[3])
        apb(1, CTRL0_ADDR, 32'h0000_00d8);
        apb(1, AUX_ADDR, 32'h0000_0044);
        apb(1, CTRL0_ADDR, 32'h0000_00f8);
        apb(0, AUX_ADDR, 0);
        `CHK("divkeep", 5'h04, rv[4:0])
        apb(1, CTRL0_ADDR, 32'h0000_00d8);
        apb(1, AUX_ADDR, 32'h0000_0008);
        repeat (20) @(posedge pclk);
        apb(1, CTRL0_ADDR, 32'h0000_0050);
        mode.stop_mode <= 1'b1;
        repeat (8) @(posedge pclk);
        edges(40);
        `CHK("stopcpu", 0, ec[8])
        mode.stop_mode <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(0, CTRL0_ADDR, 0);
        `CHK("stopdrv", 8'h58, rv[7:0])
        // Low power halts main while the stop bit still reads 0
        mode.low_power <= 1'b1;
        repeat (2) @(posedge pclk);
        apb(0, STAT_ADDR, 0);
        `CHK("lpmrun", 1'b0, rv[3])
        mode.low_power <= 1'b0;
        $display("main stop and stop mode done");
        for (int k = 0; k < 16; k++) begin
            d = $urandom;
            mode.ext_bus_mode <= d[8];
            mode.ext_pin_sel <= cgc_xpin_e'(d[10:9]);
            mode.gpio_lvl <= d[11];
            mode.ale_lvl <= d[12];
            mode.bus_clk_lvl <= d[13];
            apb(1, CTRL0_ADDR, {24'h0, 2'b01, 2'b01, d[3:0]});
            apb(0, CTRL0_ADDR, 0);
            `CHK("rnd", {4'h5, d[3:0]}, rv[7:0])
            `CHK("rgpio", exp_gpio(d[8], d[1:0]), clk_out.clock_output_is_gpio)
            if (d[8] && d[10]) `CHK("rlow", 1'b0, clk_out.clock_output_pin)
            if (d[8] || d[1:0] == 2'b00) `CHK("rpin", exp_pin(d), clk_out.clock_output_pin)
            apb(0, 12'h400 | {d[17:14], 2'b00}, 0);
            `CHK("unmapped", 1'b1, er)
        end
        $display("random done");
        apb(1, AUX_ADDR, 32'h0000_0088);
        lose <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(0, AUX_ADDR, 0);
        `CHK("intsel", 1'b1, rv[6])
        `CHK("intrun", 1'b1, osc_ctl.int_run)
        $display("loss done");
        give_verdict();
    end
endmodule
